// [logic/tcc_pkg.sv]
`default_nettype none

package tcc_pkg;

	// Sizes
	localparam int NUM_CH = 8;
	localparam int NUM_PAIR = 4;
	localparam int NUM_FAULT = 4;
	localparam int NUM_FILT_CH = 4;
	localparam int NUM_IN = NUM_CH + NUM_FAULT + 2;
	localparam int CNT_W = 16;
	localparam int FILT_W = 4;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int NUM_FLAGS = 11;

	// Register indices (the plain port addresses registers by index)
	localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] REG_COUNT = 5'h01;
	localparam logic [ADDR_W-1:0] REG_MOD = 5'h02;
	localparam logic [ADDR_W-1:0] REG_IEN = 5'h03;
	localparam logic [ADDR_W-1:0] REG_IEN_SET = 5'h04;
	localparam logic [ADDR_W-1:0] REG_IEN_CLR = 5'h05;
	localparam logic [ADDR_W-1:0] REG_STATUS = 5'h06;
	localparam logic [ADDR_W-1:0] REG_SWCTRL = 5'h07;
	localparam logic [ADDR_W-1:0] REG_FAULT = 5'h08;
	localparam logic [ADDR_W-1:0] REG_QUAD = 5'h09;
	localparam logic [1:0] REG_CHCFG_HI = 2'h2;
	localparam logic [1:0] REG_CHVAL_HI = 2'h3;

	// Field positions
	localparam int CTRL_ENC_BIT = 2;
	localparam int SW_VAL_LSB = 8;
	localparam int FLT_POL_LSB = 4;
	localparam int FLT_FEN_LSB = 8;
	localparam int FLT_VAL_LSB = 12;
	localparam int QUAD_POLB_BIT = 1;
	localparam int QUAD_VAL_LSB = 4;
	localparam int FLAG_FAULT = 8;
	localparam int FLAG_OVF = 9;
	localparam int FLAG_RELOAD = 10;

	// Reset values and timing
	localparam logic [CNT_W-1:0] MOD_RST = 16'hFFFF;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [3:0] DIV_LAST = 4'h7;

	// Modes and selects
	typedef enum logic [1:0] {CLK_NONE, CLK_CORE, CLK_DIV, CLK_QUAD} tcc_clk_sel_t;
	typedef enum logic [1:0] {MODE_OFF, MODE_CAPTURE, MODE_COMPARE, MODE_DUAL} tcc_mode_t;
	typedef enum logic [1:0] {EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_BOTH} tcc_edge_t;
	typedef enum logic [1:0] {ACT_NONE, ACT_TOGGLE, ACT_CLEAR, ACT_SET} tcc_action_t;

	// Channel configuration word, bit 0 upward: mode, edge, action, cont, filter
	typedef struct packed {
		logic [FILT_W-1:0] filt;
		logic cont;
		tcc_action_t action;
		tcc_edge_t edge_sel;
		tcc_mode_t mode;
	} tcc_chcfg_t;

	localparam int CHCFG_W = $bits(tcc_chcfg_t);

	// Register port request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} tcc_bus_t;

endpackage

`default_nettype wire

// [logic/tcc_timer.sv]
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// [R1] Compare channel changes its output by the selected action on counter match.
// [R2] Capture channel copies counter into its value register on the selected edge.
// [R3] Pair dual-edge capture, edge selectable, one-shot or continuous, values in both.
// [R4] Four channel pairs, zero to three, for paired functions.
// [R5] Dual-edge filter exists only on channels 0 and 2; zero disables it.
// [R6] Single capture filter only on channels 0-3; zero bypasses it.
// [R7] Quadrature decoder from phases A and B, polarity each, selectable encoding.
// [R8] Four fault inputs, each with own active level and filter.
// [R9] Interrupt enable bits set and cleared by mask, readable as one word.
// [R10] Status flags read as one word, cleared by mask in one write.
// [R11] Counter stopped until a clock source is selected, then runs from it.
// [R12] Per-channel software control enable overrides the channel function.
// [R13] Per-channel software value drives output while software control is enabled.
// [R14] No source halts counter, holding value, with no compare, capture, overflow.
// [R15] Mask clear touches only masked flags; a same-cycle set wins.
module tcc_timer (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Register port
	input wire tcc_pkg::tcc_bus_t bus,
	output logic [tcc_pkg::DATA_W-1:0] rdata,
	// Channel pins
	input wire logic [tcc_pkg::NUM_CH-1:0] ch_in,
	output logic [tcc_pkg::NUM_CH-1:0] ch_out,
	// Quadrature phases and faults
	input wire logic phase_a,
	input wire logic phase_b,
	input wire logic [tcc_pkg::NUM_FAULT-1:0] fault_in
);
	import tcc_pkg::*;

	// Software state
	tcc_clk_sel_t counter_clock_select;
	logic quadrature_encoding_select;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] modulo;
	logic [NUM_FLAGS-1:0] int_enable;
	logic [NUM_FLAGS-1:0] status;
	logic [NUM_CH-1:0] sw_en;
	logic [NUM_CH-1:0] sw_val;
	logic [15:0] fault_cfg;
	logic [7:0] quad_cfg;
	tcc_chcfg_t chcfg [NUM_CH];
	logic [CNT_W-1:0] channel_value_register [NUM_CH];
	logic [NUM_CH-1:0] cmp_out;
	logic [3:0] div_cnt;

	// Write decode
	wire wr_ctrl = bus.wr && bus.addr == REG_CTRL;
	wire wr_count = bus.wr && bus.addr == REG_COUNT;
	wire wr_mod = bus.wr && bus.addr == REG_MOD;
	wire wr_ien_set = bus.wr && bus.addr == REG_IEN_SET;
	wire wr_ien_clr = bus.wr && bus.addr == REG_IEN_CLR;
	wire wr_status = bus.wr && bus.addr == REG_STATUS;
	wire wr_sw = bus.wr && bus.addr == REG_SWCTRL;
	wire wr_fault = bus.wr && bus.addr == REG_FAULT;
	wire wr_quad = bus.wr && bus.addr == REG_QUAD;
	wire [2:0] sel_ch = bus.addr[2:0];
	wire wr_chcfg = bus.wr && bus.addr[4:3] == REG_CHCFG_HI;
	wire wr_chval = bus.wr && bus.addr[4:3] == REG_CHVAL_HI;

	// Input filters: channels, faults, phases share one structure
	wire [NUM_IN-1:0] raw_in = {phase_b, phase_a, fault_in, ch_in};
	logic [FILT_W-1:0] filt_set [NUM_IN];
	logic [NUM_IN-1:0] filt_in;
	logic [NUM_IN-1:0] filt_prev;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_IN; gi++) begin : g_filt
			logic [FILT_W-1:0] fcnt;
			logic fstate;
			// Setting per input; channels above 3 have none
			if (gi < NUM_FILT_CH) begin : g_chf
				assign filt_set[gi] = chcfg[gi].filt; // [R5] [R6]
			end else if (gi < NUM_CH) begin : g_chn
				assign filt_set[gi] = '0; // [R6]
			end else if (gi < NUM_CH + NUM_FAULT) begin : g_flt
				assign filt_set[gi] = fault_cfg[FLT_FEN_LSB + gi - NUM_CH] ?
					fault_cfg[FLT_VAL_LSB +: FILT_W] : '0; // [R8]
			end else begin : g_qd
				assign filt_set[gi] = quad_cfg[QUAD_VAL_LSB +: FILT_W]; // [R7]
			end
			// Zero setting passes the pin straight through
			assign filt_in[gi] = (filt_set[gi] == '0) ? raw_in[gi] : fstate; // [R5] [R6]
			// Level must hold for the set number of cycles
			always_ff @(posedge core_clk) begin
				if (srst) begin
					fcnt <= '0;
					fstate <= 1'b0;
				end else if (raw_in[gi] == fstate) begin
					fcnt <= '0;
				end else if (fcnt >= filt_set[gi] - 1'b1) begin
					fcnt <= '0;
					fstate <= raw_in[gi];
				end else begin
					fcnt <= fcnt + 1'b1;
				end
			end
		end
	endgenerate

	// Previous filtered levels for edge detection
	always_ff @(posedge core_clk) begin
		if (srst) begin
			filt_prev <= '0;
		end else begin
			filt_prev <= filt_in;
		end
	end

	// Quadrature phases with their polarity
	wire qa = filt_in[NUM_CH + NUM_FAULT] ^ quad_cfg[0];
	wire qb = filt_in[NUM_CH + NUM_FAULT + 1] ^ quad_cfg[QUAD_POLB_BIT];
	wire qa_prev = filt_prev[NUM_CH + NUM_FAULT] ^ quad_cfg[0];
	wire qb_prev = filt_prev[NUM_CH + NUM_FAULT + 1] ^ quad_cfg[QUAD_POLB_BIT];
	wire qa_rise = qa && !qa_prev;
	wire q_change = (qa != qa_prev) || (qb != qb_prev);
	// Encoding 0: count A rising edges, B high counts up; 1: count every phase edge
	wire quad_step = quadrature_encoding_select ? q_change : qa_rise; // [R7]
	wire quad_up = quadrature_encoding_select ? (qa ^ qb_prev) : qb; // [R7]

	// Counter tick from the selected source
	wire running = counter_clock_select != CLK_NONE; // [R11] [R14]
	wire div_pulse = div_cnt == DIV_LAST;
	logic tick;
	always_comb begin
		case (counter_clock_select)
			CLK_CORE: tick = 1'b1; // [R11]
			CLK_DIV: tick = div_pulse; // [R11]
			CLK_QUAD: tick = quad_step; // [R7]
			default: tick = 1'b0; // [R14]
		endcase
	end
	wire count_up = (counter_clock_select != CLK_QUAD) || quad_up;
	wire wrap = tick && (count_up ? (count == modulo) : (count == '0)); // [R14]
	wire [CNT_W-1:0] next_count = !tick ? count :
		count_up ? (count == modulo ? '0 : count + CNT_ONE) :
		(count == '0 ? modulo : count - CNT_ONE);

	// Divider and counter
	always_ff @(posedge core_clk) begin
		if (srst) begin
			div_cnt <= '0;
			count <= '0;
		end else begin
			div_cnt <= (div_pulse || !running) ? '0 : div_cnt + 1'b1;
			count <= wr_count ? '0 : next_count; // [R11] [R14]
		end
	end

	// Edge hit for a given select
	function automatic logic edge_hit(input tcc_edge_t s, input logic rise, input logic fall);
		edge_hit = (rise && (s == EDGE_RISE || s == EDGE_BOTH)) ||
			(fall && (s == EDGE_FALL || s == EDGE_BOTH));
	endfunction

	// Dual-edge pair state
	logic [NUM_PAIR-1:0] de_stage;
	logic [NUM_PAIR-1:0] de_armed;
	logic [NUM_CH-1:0] cap_ev;
	logic [NUM_CH-1:0] cmp_ev;

	generate
		for (gi = 0; gi < NUM_PAIR; gi++) begin : g_pair
			wire rearm = wr_chcfg && sel_ch == 3'(2 * gi);
			// Even channel takes first edge, odd channel the second
			always_ff @(posedge core_clk) begin
				if (srst) begin
					de_stage[gi] <= 1'b0;
					de_armed[gi] <= 1'b0;
				end else if (rearm) begin
					de_stage[gi] <= 1'b0;
					de_armed[gi] <= 1'b1;
				end else if (cap_ev[2 * gi] && chcfg[2 * gi].mode == MODE_DUAL) begin
					de_stage[gi] <= 1'b1; // [R3]
				end else if (cap_ev[2 * gi + 1]) begin
					de_stage[gi] <= 1'b0; // [R3]
					de_armed[gi] <= chcfg[2 * gi].cont; // [R3]
				end
			end
		end

		for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
			localparam int PAIR = gi / 2;
			localparam int EVEN = 2 * PAIR;
			wire dual = chcfg[EVEN].mode == MODE_DUAL; // [R4]
			// Pair input always comes from the even channel pin
			wire src = dual ? filt_in[EVEN] : filt_in[gi];
			wire src_prev = dual ? filt_prev[EVEN] : filt_prev[gi];
			wire hit = edge_hit(chcfg[gi].edge_sel, src && !src_prev, !src && src_prev);
			wire my_turn = de_stage[PAIR] == (gi % 2 == 1);
			wire single = !dual && chcfg[gi].mode == MODE_CAPTURE;
			assign cap_ev[gi] = running && hit &&
				(single || (dual && de_armed[PAIR] && my_turn)); // [R2] [R3] [R14]
			assign cmp_ev[gi] = tick && !dual && chcfg[gi].mode == MODE_COMPARE &&
				count == channel_value_register[gi]; // [R1] [R14]

			// Channel configuration, value and compare output
			always_ff @(posedge core_clk) begin
				if (srst) begin
					chcfg[gi] <= '0;
					channel_value_register[gi] <= '0;
					cmp_out[gi] <= 1'b0;
				end else begin
					if (wr_chcfg && sel_ch == 3'(gi)) begin
						chcfg[gi] <= bus.wdata[CHCFG_W-1:0];
					end
					if (cap_ev[gi]) begin
						channel_value_register[gi] <= count; // [R2] [R3]
					end else if (wr_chval && sel_ch == 3'(gi)) begin
						channel_value_register[gi] <= bus.wdata[CNT_W-1:0];
					end
					if (cmp_ev[gi]) begin
						case (chcfg[gi].action)
							ACT_TOGGLE: cmp_out[gi] <= !cmp_out[gi]; // [R1]
							ACT_CLEAR: cmp_out[gi] <= 1'b0; // [R1]
							ACT_SET: cmp_out[gi] <= 1'b1; // [R1]
							default: cmp_out[gi] <= cmp_out[gi];
						endcase
					end
				end
			end
		end
	endgenerate

	// Pin output: software control overrides the channel function
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ch_out <= '0;
		end else begin
			ch_out <= (sw_en & sw_val) | (~sw_en & cmp_out); // [R12] [R13]
		end
	end

	// Fault detection with per-input active level
	wire [NUM_FAULT-1:0] fault_lvl = filt_in[NUM_CH +: NUM_FAULT];
	wire [NUM_FAULT-1:0] fault_pol = fault_cfg[FLT_POL_LSB +: NUM_FAULT];
	wire [NUM_FAULT-1:0] fault_en = fault_cfg[NUM_FAULT-1:0];
	wire fault_act = |(fault_en & ~(fault_lvl ^ fault_pol)); // [R8]

	// Flag sources and mask clear
	wire [NUM_FLAGS-1:0] flag_set = {wrap, wrap, fault_act, cap_ev | cmp_ev};
	wire [NUM_FLAGS-1:0] flag_clr = wr_status ? bus.wdata[NUM_FLAGS-1:0] : '0;
	wire [NUM_FLAGS-1:0] next_status = (status & ~flag_clr) | flag_set; // [R10] [R15]

	// Control registers
	always_ff @(posedge core_clk) begin
		if (srst) begin
			counter_clock_select <= CLK_NONE;
			quadrature_encoding_select <= 1'b0;
			modulo <= MOD_RST;
			int_enable <= '0;
			status <= '0;
			sw_en <= '0;
			sw_val <= '0;
			fault_cfg <= '0;
			quad_cfg <= '0;
		end else begin
			if (wr_ctrl) begin
				counter_clock_select <= tcc_clk_sel_t'(bus.wdata[1:0]); // [R11] [R14]
				quadrature_encoding_select <= bus.wdata[CTRL_ENC_BIT]; // [R7]
			end
			if (wr_mod) begin
				modulo <= bus.wdata[CNT_W-1:0];
			end
			if (wr_ien_set) begin
				int_enable <= int_enable | bus.wdata[NUM_FLAGS-1:0]; // [R9]
			end else if (wr_ien_clr) begin
				int_enable <= int_enable & ~bus.wdata[NUM_FLAGS-1:0]; // [R9]
			end
			status <= next_status; // [R10] [R15]
			if (wr_sw) begin
				sw_en <= bus.wdata[NUM_CH-1:0]; // [R12]
				sw_val <= bus.wdata[SW_VAL_LSB +: NUM_CH]; // [R13]
			end
			if (wr_fault) begin
				fault_cfg <= bus.wdata[15:0]; // [R8]
			end
			if (wr_quad) begin
				quad_cfg <= bus.wdata[7:0]; // [R7]
			end
		end
	end

	// Read selection
	logic [DATA_W-1:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		case (bus.addr)
			REG_CTRL: rd_mux[CTRL_ENC_BIT:0] = {quadrature_encoding_select,
				counter_clock_select};
			REG_COUNT: rd_mux[CNT_W-1:0] = count;
			REG_MOD: rd_mux[CNT_W-1:0] = modulo;
			REG_IEN: rd_mux[NUM_FLAGS-1:0] = int_enable; // [R9]
			REG_STATUS: rd_mux[NUM_FLAGS-1:0] = status; // [R10]
			REG_SWCTRL: rd_mux[15:0] = {sw_val, sw_en};
			REG_FAULT: rd_mux[15:0] = fault_cfg;
			REG_QUAD: rd_mux[7:0] = quad_cfg;
			default: begin
				if (bus.addr[4:3] == REG_CHCFG_HI) begin
					rd_mux[CHCFG_W-1:0] = chcfg[sel_ch];
				end else if (bus.addr[4:3] == REG_CHVAL_HI) begin
					rd_mux[CNT_W-1:0] = channel_value_register[sel_ch];
				end
			end
		endcase
	end

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rdata <= '0;
		end else begin
			rdata <= bus.rd ? rd_mux : '0;
		end
	end

endmodule // tcc_timer

`default_nettype wire

// [tb/tcc_timer_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_chk (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Register port
	input wire tcc_pkg::tcc_bus_t bus,
	input wire logic [tcc_pkg::DATA_W-1:0] rdata,
	// Pins
	input wire logic [tcc_pkg::NUM_CH-1:0] ch_in,
	input wire logic [tcc_pkg::NUM_CH-1:0] ch_out,
	input wire logic phase_a,
	input wire logic phase_b,
	input wire logic [tcc_pkg::NUM_FAULT-1:0] fault_in
);
	import tcc_pkg::*;
	logic [1:0] sel_q;
	logic [1:0] quiet;
	wire ctl_wr = bus.wr && (bus.addr == REG_CTRL || bus.addr == REG_SWCTRL);
	// Clock select and cycles since a control write
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sel_q <= 2'h0;
			quiet <= 2'h0;
		end else begin
			if (bus.wr && bus.addr == REG_CTRL) sel_q <= bus.wdata[1:0];
			quiet <= ctl_wr ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	// Two counter reads back to back
	sequence cnt_rd2;
		bus.rd && bus.addr == REG_COUNT ##1 bus.rd && bus.addr == REG_COUNT;
	endsequence
	// Enable mask write followed by enable read
	sequence ien_wr(logic [ADDR_W-1:0] a);
		bus.wr && bus.addr == a ##1 bus.rd && bus.addr == REG_IEN;
	endsequence
	rd_idle_a: assert property (!$past(bus.rd) |-> rdata == '0)
		else $error("read data not zero while idle");
	halt_out_a: assert property (sel_q == 2'h0 && quiet == 2'h3 |-> $stable(ch_out))
		else $error("output moved while stopped");
	halt_count_a: assert property (sel_q == 2'h0 && quiet == 2'h3 ##0 cnt_rd2 |=>
		rdata == $past(rdata)) else $error("counter moved while stopped");
	run_count_a: assert property (sel_q == 2'h1 && quiet == 2'h3 ##0 cnt_rd2 |=>
		rdata == $past(rdata) + 32'h1 || rdata == '0) else $error("counter not stepping");
	sw_ch0_a: assert property (bus.wr && bus.addr == REG_SWCTRL && bus.wdata[0] |->
		##2 ch_out[0] == $past(bus.wdata[SW_VAL_LSB], 2)) else $error("software value ch0");
	sw_ch7_a: assert property (bus.wr && bus.addr == REG_SWCTRL && bus.wdata[7] |=>
		##1 ch_out[7] == $past(bus.wdata[15], 2)) else $error("software value ch7");
	ien_set_a: assert property (ien_wr(REG_IEN_SET) |=>
		(rdata[10:0] & $past(bus.wdata[10:0], 2)) == $past(bus.wdata[10:0], 2))
		else $error("enable set lost");
	ien_clr_a: assert property (ien_wr(REG_IEN_CLR) |=>
		(rdata[10:0] & $past(bus.wdata[10:0], 2)) == 11'h000) else $error("enable clear lost");
endmodule // tcc_timer_chk
`default_nettype wire

// [tb/tcc_timer_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_tb;
	import tcc_pkg::*;
	logic core_clk;
	logic srst;
	tcc_bus_t bus;
	logic [DATA_W-1:0] rdata;
	logic [NUM_CH-1:0] ch_in;
	logic [NUM_CH-1:0] ch_out;
	logic phase_a;
	logic phase_b;
	logic [NUM_FAULT-1:0] fault_in;
	int errors;
	int n_compared;
	logic [31:0] d;
	logic [31:0] e;
	// Device under test
	tcc_timer DUT (.core_clk(core_clk), .srst(srst), .bus(bus), .rdata(rdata), .ch_in(ch_in),
		.ch_out(ch_out), .phase_a(phase_a), .phase_b(phase_b), .fault_in(fault_in));
	// Clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Bus cycles; a write leaves the strobe for the next task to replace
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] x);
		bus <= '{a, x, 1'b1, 1'b0};
		@(posedge core_clk);
	endtask
	task automatic idle(input int n);
		bus <= '0;
		repeat (n) @(posedge core_clk);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] x);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge core_clk);
		bus <= '0;
		@(negedge core_clk);
		x = rdata;
		@(posedge core_clk);
	endtask
	task automatic rd2(input logic [ADDR_W-1:0] a, output logic [31:0] x, output logic [31:0] y);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge core_clk);
		@(negedge core_clk);
		x = rdata;
		@(posedge core_clk);
		bus <= '0;
		@(negedge core_clk);
		y = rdata;
		@(posedge core_clk);
	endtask
	task automatic pins(input logic [7:0] exp);
		@(negedge core_clk);
		chk("ch_out", {24'h0, ch_out}, {24'h0, exp});
		@(posedge core_clk);
	endtask
	// Reset values, stopped counter, unmapped index
	task automatic t_reset();
		rd(REG_MOD, d);
		chk("mod", d, 32'h0000FFFF);
		rd(5'h0A, d);
		chk("unmapped", d, 32'h0);
		rd2(REG_COUNT, d, e);
		chk("count", d | e, 32'h0);
	endtask
	// Running, halting and divided counting
	task automatic t_count();
		wr(REG_CTRL, 32'h1);
		idle(4);
		rd2(REG_COUNT, d, e);
		chk("step", e - d, 32'h1);
		wr(REG_CTRL, 32'h0);
		rd(REG_COUNT, d);
		idle(5);
		rd2(REG_COUNT, e, e);
		chk("halt", e, d);
		wr(REG_COUNT, 32'h0);
		wr(REG_CTRL, 32'h2);
		idle(80);
		wr(REG_CTRL, 32'h0);
		rd(REG_COUNT, d);
		chk("div", 32'(d >= 32'd9 && d <= 32'd11), 32'h1);
	endtask
	// Enable mask set and clear
	task automatic t_ien();
		wr(REG_IEN_SET, 32'h5A5);
		rd(REG_IEN, d);
		wr(REG_IEN_CLR, 32'h0A4);
		rd(REG_IEN, e);
		chk("ien set", d, 32'h5A5);
		chk("ien clr", e, 32'h501);
	endtask
	// Software override of the outputs
	task automatic t_sw();
		wr(REG_SWCTRL, 32'h8181);
		idle(2);
		pins(8'h81);
		wr(REG_SWCTRL, 32'h0181);
		idle(2);
		pins(8'h01);
		wr(REG_SWCTRL, 32'hFF00);
		idle(2);
		pins(8'h00);
	endtask
	// Compare set and toggle, masked clear, wrap flags
	task automatic t_cmp();
		wr(REG_COUNT, 32'h0);
		wr(REG_MOD, 32'h40);
		wr({REG_CHCFG_HI, 3'd1}, 32'h32);
		wr({REG_CHCFG_HI, 3'd2}, 32'h12);
		wr({REG_CHVAL_HI, 3'd1}, 32'h10);
		wr({REG_CHVAL_HI, 3'd2}, 32'h10);
		wr(REG_CTRL, 32'h1);
		idle(40);
		wr(REG_CTRL, 32'h0);
		idle(3);
		pins(8'h06);
		rd(REG_STATUS, d);
		chk("cmp flags", d & 32'h6, 32'h6);
		wr(REG_STATUS, 32'h2);
		rd(REG_STATUS, d);
		chk("masked clr", d & 32'h6, 32'h4);
		wr(REG_CTRL, 32'h1);
		idle(30);
		wr(REG_CTRL, 32'h0);
		rd(REG_STATUS, d);
		chk("wrap", d & 32'h600, 32'h600);
		wr(REG_STATUS, 32'h7FF);
		rd(REG_STATUS, d);
		chk("all clr", d, 32'h0);
		pins(8'h06);
	endtask
	// Edge capture and filtered capture
	task automatic t_cap();
		wr({REG_CHCFG_HI, 3'd3}, 32'h05);
		wr({REG_CHCFG_HI, 3'd0}, 32'h405);
		wr(REG_COUNT, 32'h0);
		wr(REG_CTRL, 32'h1);
		idle(4);
		ch_in <= 8'h09;
		idle(3);
		ch_in <= 8'h08;
		idle(12);
		rd(REG_STATUS, d);
		chk("short pulse", d & 32'h9, 32'h8);
		ch_in <= 8'h09;
		idle(12);
		wr(REG_CTRL, 32'h0);
		rd(REG_STATUS, d);
		chk("long pulse", d & 32'h9, 32'h9);
		rd({REG_CHVAL_HI, 3'd3}, d);
		chk("captured", 32'(d >= 32'd4 && d <= 32'd12), 32'h1);
	endtask
	// Fault active level
	task automatic t_fault();
		wr(REG_FAULT, 32'h1);
		idle(4);
		wr(REG_STATUS, 32'h7FF);
		rd(REG_STATUS, d);
		chk("fault idle", d & 32'h100, 32'h0);
		fault_in <= 4'hE;
		idle(4);
		rd(REG_STATUS, d);
		chk("fault low", d & 32'h100, 32'h100);
	endtask
	// One-shot dual-edge capture on pair two: rise then fall on the even pin
	task automatic t_dual();
		wr({REG_CHCFG_HI, 3'd5}, 32'h08);
		wr({REG_CHCFG_HI, 3'd4}, 32'h07);
		wr(REG_COUNT, 32'h0);
		wr(REG_CTRL, 32'h1);
		idle(4);
		ch_in <= 8'h19;
		idle(6);
		ch_in <= 8'h09;
		idle(6);
		ch_in <= 8'h19;
		idle(3);
		ch_in <= 8'h09;
		idle(3);
		wr(REG_CTRL, 32'h0);
		rd({REG_CHVAL_HI, 3'd4}, d);
		rd({REG_CHVAL_HI, 3'd5}, e);
		chk("dual gap", e - d, 32'h6);
		chk("dual first", 32'(d >= 32'd4 && d <= 32'd8), 32'h1);
	endtask
	// Quadrature x4 decoding, A leading B for one full cycle
	task automatic t_quad();
		wr(REG_COUNT, 32'h0);
		wr(REG_CTRL, 32'h7);
		idle(2);
		phase_a <= 1'b1;
		idle(2);
		phase_b <= 1'b1;
		idle(2);
		phase_a <= 1'b0;
		idle(2);
		phase_b <= 1'b0;
		idle(2);
		wr(REG_CTRL, 32'h0);
		rd(REG_COUNT, d);
		chk("quad", d, 32'h4);
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		errors = 0;
		n_compared = 0;
		srst = 1'b1;
		bus = '0;
		ch_in = '0;
		phase_a = 1'b0;
		phase_b = 1'b0;
		fault_in = 4'hF;
		repeat (16) @(posedge core_clk);
		srst <= 1'b0;
		t_reset();
		t_count();
		t_ien();
		t_sw();
		t_cmp();
		t_cap();
		t_fault();
		t_dual();
		t_quad();
		conclude();
	end
	// Watchdog, well beyond the few hundred cycles the tests need
	initial begin
		#200000;
		errors++;
		conclude();
	end
endmodule // tcc_timer_tb
bind tcc_timer tcc_timer_chk chk_i (.core_clk(core_clk), .srst(srst), .bus(bus), .rdata(rdata),
	.ch_in(ch_in), .ch_out(ch_out), .phase_a(phase_a), .phase_b(phase_b), .fault_in(fault_in));
`default_nettype wire
